// >>> rtl/bitret_exec.sv
// Execution unit for bit-test skip, AND with file, and the three return instructions
// Function
// - Bit-test skip: bit one runs next op; bit zero replaces it by a one-cycle NOP
// - AND accumulator with file: dest zero to accumulator, one to file; only zero flag
// - Return from interrupt pops stack to PC, sets enable bit 7, two cycles, no flags
// - Return with literal loads accumulator with immediate, PC from stack top, two cycles
// - Plain return pops stack top into PC, two cycles, no flags
`timescale 1ns/1ps
module bitret_exec
  import bitret_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input  wire logic              MCLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              INSTR_VALID_I,
  input  wire logic [WORD_W-1:0] INSTR_I,
  input  wire logic [DATA_W-1:0] FILE_RDATA_I,
  input  wire logic              PUSH_I,
  input  wire logic [PC_W-1:0]   PUSH_ADDR_I,
  output logic [FADDR_W-1:0]     FILE_ADDR_O,
  output logic                   FILE_WE_O,
  output logic [DATA_W-1:0]      FILE_WDATA_O,
  output logic [DATA_W-1:0]      ACC_O,
  output logic                   ZERO_FLAG_O,
  output logic [DATA_W-1:0]      INTCTL_O,
  output logic                   PC_LOAD_O,
  output logic [PC_W-1:0]        PC_O,
  output logic                   SKIP_O,
  output logic                   BUSY_O
);

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_NOP  = 2'b10
  } exec_state_t;

  exec_state_t             state_q;
  exec_state_t             state_d;
  logic [PC_W-1:0]         stack_q [DEPTH];
  logic [SP_W-1:0]         sp_q;
  logic [DATA_W-1:0]       acc_q;
  logic                    zero_q;
  logic [DATA_W-1:0]       intctl_q;
  logic [FADDR_W-1:0]      faddr_q;
  logic                    fwe_q;
  logic [DATA_W-1:0]       fwdata_q;
  logic                    pcld_q;
  logic [PC_W-1:0]         pc_q;
  logic                    skip_q;
  logic                    busy_q;

  // Upper four opcode bits select the literal and bit-test groups
  function automatic logic [3:0] op_group(input logic [WORD_W-1:0] w);
    return w[13:10];
  endfunction

  // Ops only issue in the run state; the second cycle is a bubble
  wire                     issue   = INSTR_VALID_I && (state_q == ST_RUN);
  wire                     is_ret  = issue && (INSTR_I == OP_RETURN);
  wire                     is_rfi  = issue && (INSTR_I == OP_RETFROMINT);
  wire                     is_rlit = issue && (op_group(INSTR_I) == OP_RETLIT);
  wire                     is_and  = issue && (INSTR_I[13:8] == OP_ANDFILE);
  wire                     is_btst = issue && (op_group(INSTR_I) == OP_BITSKIPCLR);
  wire                     any_pop = is_ret || is_rfi || is_rlit;
  wire [2:0]               bit_idx = INSTR_I[BIT_LSB +: 3];
  wire                     tbit    = FILE_RDATA_I[bit_idx];
  wire [DATA_W-1:0]        and_res = acc_q & FILE_RDATA_I;
  wire [SP_W-1:0]          sp_dec  = sp_q - 3'h1;
  wire [PC_W-1:0]          top_of_return_stack     = stack_q[sp_dec];
  wire                     skip_take = is_btst && !tbit;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
      begin
        if (any_pop || skip_take) state_d = ST_NOP;
      end
      ST_NOP:  state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  // Stack wraps silently on overflow, like a circular return stack
  always_ff @(posedge MCLK_I)
  begin
    if (PUSH_I && !any_pop) stack_q[sp_q] <= PUSH_ADDR_I;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_q  <= ST_RUN;
      sp_q     <= SP_RST;
      acc_q    <= ACC_RST;
      zero_q   <= 1'b0;
      intctl_q <= INTCTL_RST;
      faddr_q  <= '0;
      fwe_q    <= 1'b0;
      fwdata_q <= ACC_RST;
      pcld_q   <= 1'b0;
      pc_q     <= PC_RST;
      skip_q   <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      fwe_q   <= 1'b0;
      pcld_q  <= 1'b0;
      skip_q  <= skip_take;
      // Busy kept in its own flop so the output comes straight from a register
      busy_q  <= (state_d == ST_NOP);
      faddr_q <= INSTR_I[FADDR_W-1:0];
      if (any_pop)
      begin
        sp_q   <= sp_dec;
        pc_q   <= top_of_return_stack;
        pcld_q <= 1'b1;
      end
      else if (PUSH_I)
        sp_q <= sp_q + 3'h1;
      if (is_rfi) intctl_q[INTEN_POS] <= 1'b1;
      if (is_rlit) acc_q <= INSTR_I[DATA_W-1:0];
      if (is_and)
      begin
        zero_q <= (and_res == 8'h00);
        if (INSTR_I[DEST_POS])
        begin
          fwe_q    <= 1'b1;
          fwdata_q <= and_res;
        end
        else
          acc_q <= and_res;
      end
    end
  end

  assign FILE_ADDR_O  = faddr_q;
  assign FILE_WE_O    = fwe_q;
  assign FILE_WDATA_O = fwdata_q;
  assign ACC_O        = acc_q;
  assign ZERO_FLAG_O  = zero_q;
  assign INTCTL_O     = intctl_q;
  assign PC_LOAD_O    = pcld_q;
  assign PC_O         = pc_q;
  assign SKIP_O       = skip_q;
  assign BUSY_O       = busy_q;

  sequence s_pop;
    any_pop;
  endsequence

  chk_skip_bubble: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (is_btst && !tbit) |=> SKIP_O && BUSY_O ##1 !BUSY_O)
    else $error("skip did not give one nop cycle");
  chk_skip_none: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (is_btst && tbit) |=> !SKIP_O && !BUSY_O)
    else $error("set bit caused a skip");
  chk_and_acc: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (is_and && !INSTR_I[DEST_POS]) |=> ACC_O == $past(and_res) && !FILE_WE_O)
    else $error("and to accumulator wrong");
  chk_and_file: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (is_and && INSTR_I[DEST_POS]) |=> FILE_WE_O && FILE_WDATA_O == $past(and_res)
      && ZERO_FLAG_O == (FILE_WDATA_O == 8'h00) && $stable(ACC_O))
    else $error("and to file wrong");
  chk_rfi_enable: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_rfi |=> INTCTL_O[INTEN_POS] && PC_LOAD_O && $stable(ZERO_FLAG_O))
    else $error("interrupt return did not enable");
  chk_rlit_acc: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_rlit |=> ACC_O == $past(INSTR_I[DATA_W-1:0]) && PC_O == $past(top_of_return_stack) && BUSY_O)
    else $error("literal return wrong");
  chk_ret_two: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_pop |=> BUSY_O && PC_LOAD_O ##1 !BUSY_O && !PC_LOAD_O)
    else $error("return not two cycles");
  chk_pop_sp: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_pop |=> sp_q == $past(sp_q) - 3'h1)
    else $error("pop did not step pointer back");

  // Second cycle of a two-cycle op: bubble, then free again
  sequence s_bubble;
    BUSY_O ##1 !BUSY_O;
  endsequence

  // A word offered in the bubble must not load the PC, write the file or skip
  chk_busy_ignore: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (BUSY_O && INSTR_VALID_I) |=> !PC_LOAD_O && !FILE_WE_O && !SKIP_O)
    else $error("word taken while busy");
  chk_skip_pulse: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    SKIP_O |=> !SKIP_O)
    else $error("skip pulse too long");
  chk_and_zero: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_and |=> ZERO_FLAG_O == ($past(and_res) == 8'h00))
    else $error("zero flag wrong after and");
  chk_and_single: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_and |=> !BUSY_O && !PC_LOAD_O && !SKIP_O)
    else $error("and took more than one cycle");

  // Returns touch no flags and keep the two-cycle shape
  chk_rfi_bubble: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_rfi |=> s_bubble)
    else $error("interrupt return not two cycles");
  chk_rlit_bubble: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_rlit |=> s_bubble)
    else $error("literal return not two cycles");
  chk_rlit_flags: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_rlit |=> $stable(ZERO_FLAG_O) && $stable(INTCTL_O) && !FILE_WE_O)
    else $error("literal return changed flags");
  chk_ret_flags: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    is_ret |=> $stable(ZERO_FLAG_O) && $stable(ACC_O) && $stable(INTCTL_O))
    else $error("plain return changed state");

  // Pointer walks up on push and hands back the latest entry on pop
  chk_push_step: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (PUSH_I && !any_pop) |=> sp_q == $past(sp_q) + 3'h1)
    else $error("push did not step pointer");
  chk_pop_addr: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_pop |=> PC_O == $past(top_of_return_stack))
    else $error("pop gave wrong address");

endmodule

// >>> inc/bitret_pkg.sv
// Package of encodings and constants for the bit-test and return execution unit
package bitret_pkg;
  localparam int          WORD_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          FADDR_W       = 7;
  localparam int          PC_W          = 13;
  localparam int          STACK_DEPTH   = 8;
  localparam int          SP_W          = 3;
  // Opcode match patterns on the 14-bit instruction word
  localparam logic [13:0] OP_RETURN     = 14'h0008;
  localparam logic [13:0] OP_RETFROMINT = 14'h0009;
  localparam logic [5:0]  OP_ANDFILE    = 6'h05;
  localparam logic [3:0]  OP_BITSKIPCLR = 4'h6;
  localparam logic [3:0]  OP_RETLIT     = 4'hD;
  // Field positions
  localparam int          DEST_POS      = 7;
  localparam int          BIT_LSB       = 7;
  localparam int          INTEN_POS     = 7;
  // Reset values and cycle counts
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [7:0]  INTCTL_RST    = 8'h00;
  localparam logic [12:0] PC_RST        = 13'h0000;
  localparam logic [2:0]  SP_RST        = 3'h0;
  localparam int          TWO_CYCLE     = 2;
endpackage

// >>> verif/testbench.sv
// Random self-checking bench for the bit-test and return unit
`timescale 1ns/1ps
module testbench
  import bitret_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               vld = 1'b0;
  logic               push = 1'b0;
  logic [WORD_W-1:0]  instr = '0;
  logic [DATA_W-1:0]  rdata = '0;
  logic [PC_W-1:0]    paddr = '0;
  logic [FADDR_W-1:0] fa;
  logic               fwe, zf, pcl, skp, bsy;
  logic [DATA_W-1:0]  fwd, acc, ictl;
  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    stk[$];
  int                 mismatches = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  bitret_exec dut (.MCLK_I(clk), .SYS_RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(instr),
    .FILE_RDATA_I(rdata), .PUSH_I(push), .PUSH_ADDR_I(paddr), .FILE_ADDR_O(fa),
    .FILE_WE_O(fwe), .FILE_WDATA_O(fwd), .ACC_O(acc), .ZERO_FLAG_O(zf), .INTCTL_O(ictl),
    .PC_LOAD_O(pcl), .PC_O(pc), .SKIP_O(skp), .BUSY_O(bsy));
  initial
    forever #20 clk = ~clk;
  function automatic logic skip_exp(logic [7:0] f, logic [2:0] b);
    return ~f[b];
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  // Drive one word; returns just after the taking edge so results are settled
  task automatic issue(input logic [WORD_W-1:0] w, input logic [DATA_W-1:0] f);
    @(posedge clk);
    vld <= 1'b1;
    instr <= w;
    rdata <= f;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic push_one(input logic [PC_W-1:0] a);
    @(posedge clk);
    push <= 1'b1;
    paddr <= a;
    @(posedge clk);
    push <= 1'b0;
    stk.push_back(a);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is under 200 cycles; generous ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    logic [DATA_W-1:0]  f, r, k;
    logic [DATA_W-1:0]  a_exp;
    logic [FADDR_W-1:0] fr;
    logic [2:0]         b;
    logic               z_exp;
    a_exp = ACC_RST;
    z_exp = 1'b0;
    void'($urandom(78860));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val(ictl, INTCTL_RST);
    repeat (4)
    begin
      for (int i = 0; i < 3; i++)
        push_one(PC_W'($urandom));
      for (int i = 0; i < 3; i++)
      begin
        k = 8'($urandom);
        issue(i == 0 ? OP_RETURN : i == 1 ? OP_RETFROMINT : {OP_RETLIT, 2'b00, k}, 8'h00);
        if (i == 2)
          a_exp = k;
        chk_bit(pcl, 1'b1);
        chk_val(pc, stk.pop_back());
        chk_val(acc, a_exp);
        chk_bit(bsy, 1'b1);
        chk_bit(zf, z_exp);
      end
      chk_bit(ictl[INTEN_POS], 1'b1);
      for (int i = 0; i < 2; i++)
      begin
        // Zero operand now and then, so the flag is seen both ways
        f = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
        fr = 7'($urandom);
        r = a_exp & f;
        issue({OP_ANDFILE, i[0], fr}, f);
        if (i[0] == 1'b0)
          a_exp = r;
        z_exp = (r == 8'h00);
        chk_bit(fwe, i[0]);
        chk_val(i[0] ? fwd : acc, r);
        chk_val(acc, a_exp);
        chk_bit(zf, z_exp);
        chk_val(fa, fr);
      end
      b = 3'($urandom);
      f = 8'($urandom);
      issue({OP_BITSKIPCLR, b, 7'h7F}, f);
      chk_bit(skp, skip_exp(f, b));
      chk_bit(bsy, skip_exp(f, b));
    end
    // Word held through the bubble must be refused
    push_one(13'h0ABC);
    @(posedge clk);
    vld <= 1'b1;
    instr <= OP_RETURN;
    @(posedge clk);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk_bit(pcl, 1'b0);
    chk_bit(bsy, 1'b0);
    chk_val(pc, stk.pop_back());
    // Reset in mid-run clears the visible state
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val(acc, ACC_RST);
    chk_val(ictl, INTCTL_RST);
    chk_val(pc, PC_RST);
    conclude();
  end
endmodule
